/* rtl/radio_mode_sequencer.sv */
// module: top-level radio mode sequencer with two periodic timers
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01: idle waits for launch, then follows from_idle_sel
// RULE_02: idle state without launch leaves chip mode untouched
// RULE_03: action ending into idle forces sleep mode
// RULE_04: await fifo holds until fifo level, then transmits
// RULE_05: dormant is standby/sleep, reacts to timer a only
// RULE_06: held state keeps receiver on, packet kept
// RULE_07: relaunch restarts receiver for fresh gain/frequency
// RULE_08: from_idle_sel picks dormant/idle, rx, tx, fifo wait
// RULE_09: end_state_sel: 0 idle, 1 dormant
// RULE_10: timer a in dormant: 0 transmit, 1 receive
// RULE_11: tx done: 0 end state, 1 receive
// RULE_12: from_rx_sel codes pick payload/level/sync/preamble exits
// RULE_13: code 011 uses crc pass, payload if crc off
// RULE_14: timer b in receive always goes end state
// RULE_15: rx expiry follows from_timeout_sel
// RULE_16: from_held_sel picks idle, drained exits, return receive
// RULE_17: software launches only in sleep or standby; the block does not check chip_mode_o and takes a launch in any mode while idle
// RULE_18: halt forces idle from any state
// RULE_19: timer resolution selects tick; period tick times coefficient
// RULE_20: mode codes sleep 000 through receive 101
// RULE_21: entering tx, rx, relaunch, held or dormant drives matching chip mode
// RULE_22: one event pulse, at most one transition
module radio_mode_sequencer (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic seq_launch_cmd_i,
    input wire logic seq_halt_cmd_i,
    input wire radio_seq_pkg::seq_cfg_s cfg_i,
    input wire radio_seq_pkg::tmr_cfg_s tmr_a_cfg_i,
    input wire radio_seq_pkg::tmr_cfg_s tmr_b_cfg_i,
    input wire radio_seq_pkg::seq_evt_s evt_i,
    output logic [2:0] chip_mode_o,
    output logic mode_write_o,
    output logic rx_restart_o,
    output logic seq_busy_o,
    output logic [2:0] seq_state_o
);

    // ------------------------------------------------------------
    // periodic timers
    // ------------------------------------------------------------
    logic [1:0] tmr_fire;
    logic [1:0] tmr_run;
    radio_seq_pkg::seq_state_e state_q;
    radio_seq_pkg::seq_state_e state_d;
    logic entered;

    // timer a runs in dormant, timer b in receive; both restart on entry
    assign tmr_run[0] = (state_q == radio_seq_pkg::ST_DORMANT) && !entered;
    assign tmr_run[1] = (state_q == radio_seq_pkg::ST_RX) && !entered;

    generate
        for (genvar t = 0; t < 2; t++) begin : g_tmr
            radio_seq_pkg::tmr_cfg_s cfg;
            logic [radio_seq_pkg::TICK_W-1:0] tick_q;
            logic [radio_seq_pkg::TICK_W-1:0] tick_len;
            logic [radio_seq_pkg::COEF_W-1:0] coef_q;
            logic tick_end;
            assign cfg = (t == 0) ? tmr_a_cfg_i : tmr_b_cfg_i;
            // tick length from resolution field
            always_comb begin
                case (cfg.res)
                    radio_seq_pkg::RES_64US: tick_len = radio_seq_pkg::TICK_W'(radio_seq_pkg::TICK_64US_CYC); // RULE_19
                    radio_seq_pkg::RES_4MS: tick_len = radio_seq_pkg::TICK_W'(radio_seq_pkg::TICK_4MS_CYC); // RULE_19
                    radio_seq_pkg::RES_262MS: tick_len = radio_seq_pkg::TICK_W'(radio_seq_pkg::TICK_262MS_CYC);
                    default: tick_len = '0;
                endcase
            end
            assign tick_end = (tick_q == tick_len - radio_seq_pkg::TICK_W'(1));
            // tick and coefficient counters; disabled timer never fires
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    tick_q <= '0;
                    coef_q <= '0;
                end else if (!tmr_run[t] || cfg.res == radio_seq_pkg::RES_OFF) begin
                    tick_q <= '0;
                    coef_q <= '0;
                end else if (tick_end) begin
                    tick_q <= '0;
                    coef_q <= tmr_fire[t] ? '0 : coef_q + radio_seq_pkg::COEF_W'(1);
                end else begin
                    tick_q <= tick_q + radio_seq_pkg::TICK_W'(1);
                end
            end
            // period is tick times coefficient; zero coefficient acts as one
            assign tmr_fire[t] = tmr_run[t] && (cfg.res != radio_seq_pkg::RES_OFF) && tick_end
                && (coef_q + radio_seq_pkg::COEF_W'(1) >= cfg.coef); // RULE_19
        end
    endgenerate

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    logic end_dormant;
    radio_seq_pkg::seq_state_e end_state;
    assign end_dormant = cfg_i.end_state_sel; // RULE_09
    assign end_state = end_dormant ? radio_seq_pkg::ST_DORMANT : radio_seq_pkg::ST_IDLE; // RULE_09

    logic held_trig;
    logic timeout_trig;
    // crc option: payload stands in for crc pass when crc is off
    assign held_trig = (cfg_i.from_rx_sel == radio_seq_pkg::RX_CRC_HELD)
        && (evt_i.crc_pass_irq || (!cfg_i.crc_enable && evt_i.rx_payload_irq)); // RULE_13
    assign timeout_trig = evt_i.rx_expiry_irq
        || (evt_i.rx_payload_irq && cfg_i.from_rx_sel == radio_seq_pkg::RX_CRC_HELD && cfg_i.crc_enable); // RULE_15

    // set when the chosen exit is the end-of-action one, so the mode logic can sleep the chip
    logic ends_action;

    // next state; each case examines only its own events
    always_comb begin
        state_d = state_q;
        ends_action = 1'b0;
        case (state_q)
            radio_seq_pkg::ST_IDLE: begin
                if (seq_launch_cmd_i) begin // RULE_01
                    case (cfg_i.from_idle_sel) // RULE_08
                        radio_seq_pkg::IDLE_TO_END: begin
                            state_d = end_state;
                            ends_action = 1'b1; // RULE_03
                        end
                        radio_seq_pkg::IDLE_TO_RX: state_d = radio_seq_pkg::ST_RX;
                        radio_seq_pkg::IDLE_TO_TX: state_d = radio_seq_pkg::ST_TX;
                        default: state_d = radio_seq_pkg::ST_AWAIT_FIFO;
                    endcase
                end
            end
            radio_seq_pkg::ST_AWAIT_FIFO: begin
                if (evt_i.fifo_level_irq) begin
                    state_d = radio_seq_pkg::ST_TX; // RULE_04
                end
            end
            radio_seq_pkg::ST_DORMANT: begin
                if (tmr_fire[0]) begin // RULE_05
                    state_d = cfg_i.from_lowpwr_sel ? radio_seq_pkg::ST_RX : radio_seq_pkg::ST_TX; // RULE_10
                end
            end
            radio_seq_pkg::ST_TX: begin
                if (evt_i.tx_done_irq) begin
                    state_d = cfg_i.from_tx_sel ? radio_seq_pkg::ST_RX : end_state; // RULE_11
                    ends_action = !cfg_i.from_tx_sel;
                end
            end
            radio_seq_pkg::ST_RX: begin
                if (tmr_fire[1]) begin
                    state_d = end_state; // RULE_14
                    ends_action = 1'b1;
                end else if (held_trig) begin
                    state_d = radio_seq_pkg::ST_PKT_HELD; // RULE_13
                end else if (timeout_trig) begin
                    case (cfg_i.from_timeout_sel) // RULE_15
                        radio_seq_pkg::TO_RELAUNCH: state_d = radio_seq_pkg::ST_RX_RELAUNCH;
                        radio_seq_pkg::TO_TX: state_d = radio_seq_pkg::ST_TX;
                        radio_seq_pkg::TO_END: begin
                            state_d = end_state;
                            ends_action = 1'b1;
                        end
                        default: state_d = radio_seq_pkg::ST_IDLE;
                    endcase
                end else begin
                    case (cfg_i.from_rx_sel) // RULE_12
                        radio_seq_pkg::RX_PAYLOAD_HELD:
                            if (evt_i.rx_payload_irq) state_d = radio_seq_pkg::ST_PKT_HELD;
                        radio_seq_pkg::RX_PAYLOAD_END:
                            if (evt_i.rx_payload_irq) begin
                                state_d = end_state;
                                ends_action = 1'b1;
                            end
                        radio_seq_pkg::RX_LEVEL_IDLE:
                            if (evt_i.signal_level_irq) state_d = radio_seq_pkg::ST_IDLE;
                        radio_seq_pkg::RX_SYNC_IDLE:
                            if (evt_i.sync_match_irq) state_d = radio_seq_pkg::ST_IDLE;
                        radio_seq_pkg::RX_PREAMBLE_IDLE:
                            if (evt_i.preamble_seen_irq) state_d = radio_seq_pkg::ST_IDLE;
                        default: state_d = state_q;
                    endcase
                end
            end
            radio_seq_pkg::ST_PKT_HELD: begin
                case (cfg_i.from_held_sel) // RULE_16
                    radio_seq_pkg::HELD_IDLE: state_d = radio_seq_pkg::ST_IDLE;
                    radio_seq_pkg::HELD_DRAIN_TX:
                        if (evt_i.fifo_drained_irq) state_d = radio_seq_pkg::ST_TX;
                    radio_seq_pkg::HELD_DRAIN_END:
                        if (evt_i.fifo_drained_irq) begin
                            state_d = end_state;
                            ends_action = 1'b1;
                        end
                    radio_seq_pkg::HELD_RX_VIA_FS: state_d = radio_seq_pkg::ST_RX;
                    radio_seq_pkg::HELD_RX: state_d = radio_seq_pkg::ST_RX;
                    default: state_d = state_q;
                endcase
            end
            radio_seq_pkg::ST_RX_RELAUNCH: state_d = radio_seq_pkg::ST_RX; // RULE_07
            default: state_d = radio_seq_pkg::ST_IDLE;
        endcase
    end

    // state register; halt overrides everything
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= radio_seq_pkg::ST_IDLE;
        end else if (seq_halt_cmd_i) begin
            state_q <= radio_seq_pkg::ST_IDLE; // RULE_18
        end else begin
            state_q <= state_d; // RULE_22
        end
    end

    // first cycle in a state, used to restart the timers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            entered <= 1'b0;
        end else begin
            entered <= !seq_halt_cmd_i && (state_d != state_q);
        end
    end

    // ------------------------------------------------------------
    // chip mode drive
    // ------------------------------------------------------------
    logic [2:0] mode_d;
    logic mode_wr_d;
    logic going;
    logic via_fs;
    assign going = !seq_halt_cmd_i && (state_d != state_q);
    assign via_fs = (state_q == radio_seq_pkg::ST_PKT_HELD)
        && (cfg_i.from_held_sel == radio_seq_pkg::HELD_RX_VIA_FS) && cfg_i.freq_changed;

    // mode written on entry to tx, rx, relaunch, held and dormant and when an action ends in idle; halt writes nothing
    always_comb begin
        mode_d = chip_mode_o;
        mode_wr_d = 1'b0;
        if (going || (!seq_halt_cmd_i && ends_action)) begin
            mode_wr_d = 1'b1;
            case (state_d)
                radio_seq_pkg::ST_TX: mode_d = radio_seq_pkg::MODE_TX; // RULE_21
                radio_seq_pkg::ST_RX,
                radio_seq_pkg::ST_RX_RELAUNCH: mode_d = via_fs ? radio_seq_pkg::MODE_FS_RX : radio_seq_pkg::MODE_RX;
                radio_seq_pkg::ST_PKT_HELD: mode_d = radio_seq_pkg::MODE_RX; // RULE_06
                radio_seq_pkg::ST_DORMANT: // RULE_05
                    mode_d = cfg_i.lowpwr_standby ? radio_seq_pkg::MODE_STANDBY : radio_seq_pkg::MODE_SLEEP;
                radio_seq_pkg::ST_IDLE: begin
                    // an action ending in idle puts the chip to sleep; other idle entries leave it
                    if (ends_action) begin
                        mode_d = radio_seq_pkg::MODE_SLEEP; // RULE_03
                    end else begin
                        mode_wr_d = 1'b0; // RULE_02
                    end
                end
                default: mode_wr_d = 1'b0;
            endcase
        end
    end

    // chip mode register, sleep after reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chip_mode_o <= radio_seq_pkg::MODE_SLEEP;
            mode_write_o <= 1'b0;
            rx_restart_o <= 1'b0;
        end else begin
            chip_mode_o <= mode_d; // RULE_20
            mode_write_o <= mode_wr_d;
            rx_restart_o <= going && (state_d == radio_seq_pkg::ST_RX_RELAUNCH); // RULE_07
        end
    end

    assign seq_busy_o = (state_q != radio_seq_pkg::ST_IDLE);
    assign seq_state_o = state_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // halt wins over every state
    halt_to_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_18
        seq_halt_cmd_i |=> state_q == radio_seq_pkg::ST_IDLE) else $error("halt did not reach idle");

    // fifo level event starts the transmitter
    fifo_to_tx_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_04
        state_q == radio_seq_pkg::ST_AWAIT_FIFO && evt_i.fifo_level_irq && !seq_halt_cmd_i
        |=> state_q == radio_seq_pkg::ST_TX && chip_mode_o == radio_seq_pkg::MODE_TX)
        else $error("fifo wait exit wrong");

    // fifo wait holds without the level event
    fifo_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_04
        state_q == radio_seq_pkg::ST_AWAIT_FIFO && !evt_i.fifo_level_irq && !seq_halt_cmd_i
        |=> state_q == radio_seq_pkg::ST_AWAIT_FIFO) else $error("fifo wait left early");

    // dormant ignores everything but timer a
    dormant_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_05
        state_q == radio_seq_pkg::ST_DORMANT && !tmr_fire[0] && !seq_halt_cmd_i
        |=> state_q == radio_seq_pkg::ST_DORMANT) else $error("dormant left without timer");

    // timer a exit follows the low-power select
    lowpwr_steer_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_10
        state_q == radio_seq_pkg::ST_DORMANT && tmr_fire[0] && !seq_halt_cmd_i
        |=> state_q == ($past(cfg_i.from_lowpwr_sel) ? radio_seq_pkg::ST_RX : radio_seq_pkg::ST_TX))
        else $error("dormant exit wrong");

    // transmit done can turn around into receive
    tx_done_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_11
        state_q == radio_seq_pkg::ST_TX && evt_i.tx_done_irq && cfg_i.from_tx_sel && !seq_halt_cmd_i
        |=> state_q == radio_seq_pkg::ST_RX) else $error("tx to rx missed");

    // transmit done with end state idle sleeps the chip
    tx_end_sleep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_03
        state_q == radio_seq_pkg::ST_TX && evt_i.tx_done_irq && !cfg_i.from_tx_sel && !cfg_i.end_state_sel
        && !seq_halt_cmd_i |=> state_q == radio_seq_pkg::ST_IDLE && chip_mode_o == radio_seq_pkg::MODE_SLEEP)
        else $error("tx end not asleep");

    // timer b ends reception whatever the receive select
    rx_timer_b_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_14
        state_q == radio_seq_pkg::ST_RX && tmr_fire[1] && !cfg_i.end_state_sel && !seq_halt_cmd_i
        |=> state_q == radio_seq_pkg::ST_IDLE && chip_mode_o == radio_seq_pkg::MODE_SLEEP)
        else $error("timer b exit wrong");

    // preamble exit idles the sequencer and leaves the mode alone
    rx_preamble_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_12
        state_q == radio_seq_pkg::ST_RX && cfg_i.from_rx_sel == radio_seq_pkg::RX_PREAMBLE_IDLE
        && evt_i.preamble_seen_irq && !evt_i.rx_expiry_irq && !tmr_fire[1] && !seq_halt_cmd_i
        |=> state_q == radio_seq_pkg::ST_IDLE && !mode_write_o) else $error("preamble exit wrong");

    // held state keeps the receiver mode
    held_rx_mode_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_06
        state_q == radio_seq_pkg::ST_PKT_HELD |-> chip_mode_o == radio_seq_pkg::MODE_RX)
        else $error("held left receive");

    // drained fifo in held steers to transmit
    held_drain_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_16
        state_q == radio_seq_pkg::ST_PKT_HELD && cfg_i.from_held_sel == radio_seq_pkg::HELD_DRAIN_TX
        && evt_i.fifo_drained_irq && !seq_halt_cmd_i |=> state_q == radio_seq_pkg::ST_TX)
        else $error("held drain exit wrong");

    // relaunch lasts one cycle with the restart pulse
    relaunch_back_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_07
        state_q == radio_seq_pkg::ST_RX_RELAUNCH && !seq_halt_cmd_i
        |=> state_q == radio_seq_pkg::ST_RX ##0 $past(rx_restart_o)) else $error("relaunch wrong");

    // idle without launch never touches the chip mode
    idle_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_02
        state_q == radio_seq_pkg::ST_IDLE && !seq_launch_cmd_i |=> !mode_write_o && $stable(chip_mode_o))
        else $error("idle changed chip mode");

    // launch straight into receive
    launch_rx_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_08
        state_q == radio_seq_pkg::ST_IDLE && seq_launch_cmd_i && !seq_halt_cmd_i
        && cfg_i.from_idle_sel == radio_seq_pkg::IDLE_TO_RX
        |=> state_q == radio_seq_pkg::ST_RX && chip_mode_o == radio_seq_pkg::MODE_RX)
        else $error("launch to rx wrong");

endmodule // radio_mode_sequencer

`default_nettype wire

/* rtl/radio_seq_pkg.sv */
// package: states, mode codes, field encodings and timer constants for the radio mode sequencer
package radio_seq_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_AWAIT_FIFO,
        ST_DORMANT,
        ST_TX,
        ST_RX,
        ST_PKT_HELD,
        ST_RX_RELAUNCH
    } seq_state_e;

    // chip operating mode codes
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STANDBY = 3'h1;
    localparam logic [2:0] MODE_FS_TX = 3'h2;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_FS_RX = 3'h4;
    localparam logic [2:0] MODE_RX = 3'h5;

    // from_idle_sel codes
    localparam logic [1:0] IDLE_TO_END = 2'h0;
    localparam logic [1:0] IDLE_TO_RX = 2'h1;
    localparam logic [1:0] IDLE_TO_TX = 2'h2;
    localparam logic [1:0] IDLE_TO_FIFO = 2'h3;

    // from_rx_sel codes
    localparam logic [2:0] RX_PAYLOAD_HELD = 3'h1;
    localparam logic [2:0] RX_PAYLOAD_END = 3'h2;
    localparam logic [2:0] RX_CRC_HELD = 3'h3;
    localparam logic [2:0] RX_LEVEL_IDLE = 3'h4;
    localparam logic [2:0] RX_SYNC_IDLE = 3'h5;
    localparam logic [2:0] RX_PREAMBLE_IDLE = 3'h6;

    // from_timeout_sel codes
    localparam logic [1:0] TO_RELAUNCH = 2'h0;
    localparam logic [1:0] TO_TX = 2'h1;
    localparam logic [1:0] TO_END = 2'h2;
    localparam logic [1:0] TO_IDLE = 2'h3;

    // from_held_sel codes
    localparam logic [2:0] HELD_IDLE = 3'h0;
    localparam logic [2:0] HELD_DRAIN_TX = 3'h1;
    localparam logic [2:0] HELD_DRAIN_END = 3'h2;
    localparam logic [2:0] HELD_RX_VIA_FS = 3'h3;
    localparam logic [2:0] HELD_RX = 3'h4;

    // timer resolutions, tick times in ns and derived cycle counts at 100 MHz
    localparam logic [1:0] RES_OFF = 2'h0;
    localparam logic [1:0] RES_64US = 2'h1;
    localparam logic [1:0] RES_4MS = 2'h2;
    localparam logic [1:0] RES_262MS = 2'h3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_64US_NS = 64000;
    localparam int TICK_4MS_NS = 4100000;
    localparam int TICK_262MS_NS = 262000000;
    localparam int TICK_64US_CYC = TICK_64US_NS / CLK_PERIOD_NS;
    localparam int TICK_4MS_CYC = TICK_4MS_NS / CLK_PERIOD_NS;
    localparam int TICK_262MS_CYC = TICK_262MS_NS / CLK_PERIOD_NS;
    localparam int COEF_W = 8;
    localparam int TICK_W = 25;

    // configuration carried as one struct
    typedef struct packed {
        logic [1:0] from_idle_sel;
        logic end_state_sel;
        logic lowpwr_standby;
        logic from_lowpwr_sel;
        logic from_tx_sel;
        logic [2:0] from_rx_sel;
        logic [1:0] from_timeout_sel;
        logic [2:0] from_held_sel;
        logic crc_enable;
        logic freq_changed;
    } seq_cfg_s;

    // radio events, each a one-cycle pulse
    typedef struct packed {
        logic fifo_level_irq;
        logic tx_done_irq;
        logic rx_payload_irq;
        logic crc_pass_irq;
        logic signal_level_irq;
        logic sync_match_irq;
        logic preamble_seen_irq;
        logic rx_expiry_irq;
        logic fifo_drained_irq;
    } seq_evt_s;

    // timer settings
    typedef struct packed {
        logic [1:0] res;
        logic [COEF_W-1:0] coef;
    } tmr_cfg_s;
endpackage

/* tb/radio_mode_sequencer_tb_top.sv */
// testbench: random and directed checks of the radio mode sequencer against a bench model
`timescale 1ns/1ps
`default_nettype none
module radio_mode_sequencer_tb_top;
    // ----------------------------------------
    // stimulus, outputs and model state
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic launch = 1'b0;
    logic halt = 1'b0;
    radio_seq_pkg::seq_cfg_s cfg = '0;
    radio_seq_pkg::tmr_cfg_s tmr_a = '0;
    radio_seq_pkg::tmr_cfg_s tmr_b = '0;
    radio_seq_pkg::seq_evt_s evt = '0;
    logic [2:0] chip_mode;
    logic mode_write;
    logic rx_restart;
    logic seq_busy;
    logic [2:0] seq_state;
    int miscompares = 0;
    int compares = 0;
    int ms = 0; // model state
    int mm = 0; // model mode, -1 when not predicted
    int ns;
    int nm;
    bit mw = 1'b0; // model mode write pulse
    bit endw = 1'b0; // model step took an end-of-action exit
    logic [31:0] seed = 32'h274C;

    radio_mode_sequencer dut_u (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .seq_launch_cmd_i(launch),
        .seq_halt_cmd_i(halt),
        .cfg_i(cfg),
        .tmr_a_cfg_i(tmr_a),
        .tmr_b_cfg_i(tmr_b),
        .evt_i(evt),
        .chip_mode_o(chip_mode),
        .mode_write_o(mode_write),
        .rx_restart_o(rx_restart),
        .seq_busy_o(seq_busy),
        .seq_state_o(seq_state)
    );

    // free-running 100 MHz clock
    always #5 clk_i = ~clk_i;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic give_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic go(input int s, input int m);
        ns = s;
        nm = m;
    endtask

    // end of an action: idle in sleep, or dormant in the chosen low-power mode
    task automatic go_end();
        endw = 1'b1;
        if (cfg.end_state_sel) go(2, cfg.lowpwr_standby ? 1 : 0);
        else go(0, 0);
    endtask

    // ----------------------------------------
    // behavioural model, one edge (timers off)
    // ----------------------------------------
    task automatic step();
        logic s3;
        s3 = (cfg.from_rx_sel == radio_seq_pkg::RX_CRC_HELD);
        endw = 1'b0;
        go(ms, mm);
        if (halt) go(0, mm);
        else case (ms)
            0: if (launch) begin
                case (cfg.from_idle_sel)
                    2'h0: go_end();
                    2'h1: go(4, 5);
                    2'h2: go(3, 3);
                    default: go(1, -1);
                endcase
            end
            1: if (evt.fifo_level_irq) go(3, 3);
            3: if (evt.tx_done_irq) begin
                if (cfg.from_tx_sel) go(4, 5);
                else go_end();
            end
            4: if (s3 && (cfg.crc_enable ? evt.crc_pass_irq : evt.rx_payload_irq)) begin
                go(5, 5);
            end else if (evt.rx_expiry_irq || (s3 && cfg.crc_enable && evt.rx_payload_irq)) begin
                case (cfg.from_timeout_sel)
                    2'h0: go(6, 5);
                    2'h1: go(3, 3);
                    2'h2: go_end();
                    default: go(0, mm);
                endcase
            end else begin
                case (cfg.from_rx_sel)
                    3'h1: if (evt.rx_payload_irq) go(5, 5);
                    3'h2: if (evt.rx_payload_irq) go_end();
                    3'h4: if (evt.signal_level_irq) go(0, mm);
                    3'h5: if (evt.sync_match_irq) go(0, mm);
                    3'h6: if (evt.preamble_seen_irq) go(0, mm);
                    default: ;
                endcase
            end
            5: case (cfg.from_held_sel)
                3'h0: go(0, mm);
                3'h1: if (evt.fifo_drained_irq) go(3, 3);
                3'h2: if (evt.fifo_drained_irq) go_end();
                3'h3: go(4, cfg.freq_changed ? 4 : 5);
                default: go(4, 5);
            endcase
            6: go(4, 5);
            default: ;
        endcase
        mw = (ns != ms && ns > 1) || endw;
        ms = ns;
        mm = nm;
    endtask

    // one clock: model step, compare, then new inputs just after the edge
    task automatic cycle(input bit rand_on, input logic lch);
        logic [31:0] r;
        logic [31:0] c;
        @(posedge clk_i);
        if (rand_on) step();
        #1;
        if (rand_on) begin
            chk({5'h00, seq_state}, 8'(ms));
            chk({7'h00, seq_busy}, 8'(ms != 0));
            chk({7'h00, rx_restart}, 8'(ms == 6));
            chk({7'h00, mode_write}, 8'(mw));
            if (mm >= 0) chk({5'h00, chip_mode}, 8'(mm));
            r = rnd() & rnd() & rnd() & rnd();
            c = rnd();
            evt = r[8:0];
            launch = (c[2:0] == 3'h0) && ms == 0 && (mm == 0 || mm == 1);
            halt = (c[9:3] == 7'h00);
            if (c[14:10] == 5'h00) begin
                r = rnd();
                cfg = r[15:0];
                if (cfg.from_held_sel > 3'h4) cfg.from_held_sel = 3'h4;
            end
            evt.crc_pass_irq &= cfg.crc_enable;
        end else begin
            evt = '0;
            launch = lch;
            halt = 1'b0;
        end
    endtask

    // mid-run reset back to idle in sleep
    task automatic do_reset();
        @(posedge clk_i);
        #1 reset_n_i = 1'b0;
        evt = '0;
        launch = 1'b0;
        halt = 1'b0;
        ms = 0;
        mm = 0;
        #1;
        chk({2'h0, seq_state, chip_mode}, 8'h00);
        @(posedge clk_i);
        #1 reset_n_i = 1'b1;
    endtask

    // bounded wait for a state; the cycle count must fit the timer period
    task automatic wait_state(input int s, input int lo, input int hi);
        int n;
        n = 0;
        while (seq_state !== 3'(s) && n <= hi) begin
            cycle(1'b0, 1'b0);
            n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
        if (n > hi) give_verdict();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        for (int i = 0; i < 20000; i++) begin
            if (i % 2000 == 1999) do_reset();
            else cycle(1'b1, 1'b0);
        end
        do_reset();
        tmr_a = {radio_seq_pkg::RES_64US, 8'h00}; // coefficient 0 counts as 1
        tmr_b = {radio_seq_pkg::RES_64US, 8'h02};
        cfg = 16'h3800; // launch to dormant in standby, timer a to receive
        cycle(1'b0, 1'b1);
        cycle(1'b0, 1'b0);
        chk({2'h0, seq_state, chip_mode}, 8'h11);
        wait_state(4, 6396, 6404);
        chk({5'h00, chip_mode}, 8'h05);
        wait_state(2, 12796, 12804);
        chk({5'h00, chip_mode}, 8'h01);
        tmr_a = {radio_seq_pkg::RES_OFF, 8'h01};
        repeat (7000) cycle(1'b0, 1'b0);
        chk({5'h00, seq_state}, 8'h02);
        do_reset();
        cfg = 16'h4000; // launch to receive, end state idle
        cycle(1'b0, 1'b1);
        cycle(1'b0, 1'b0);
        chk({2'h0, seq_state, chip_mode}, 8'h25);
        wait_state(0, 12796, 12804);
        chk({5'h00, chip_mode}, 8'h00);
        give_verdict();
    end
endmodule // radio_mode_sequencer_tb_top
`default_nettype wire
